// ---- src/embedded_block_pkg.sv ----
package embedded_block_pkg;
    // register byte addresses
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] MC_TYPE_ADDR = 12'h004;
    localparam logic [11:0] MC_CFG_ADDR = 12'h008;
    localparam logic [11:0] MC_EXP_ADDR = 12'h00c;
    localparam logic [11:0] MC_CLK_ADDR = 12'h010;
    localparam logic [11:0] MC_CLR_ADDR = 12'h014;
    localparam logic [11:0] STATUS_ADDR = 12'h018;
    localparam logic [11:0] TERM_BASE_ADDR = 12'h100;
    localparam logic [11:0] TERM_END_ADDR = 12'h2fc;
    // control register field positions
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_ORG_LSB = 1;
    localparam int CTRL_OUTREG_BIT = 4;
    localparam int CTRL_CLKMODE_BIT = 5;
    localparam int CTRL_PAGEEN_BIT = 6;
    localparam int CTRL_PAGEID_LSB = 7;
    localparam int CTRL_EDGE_LSB = 9;
    localparam int CTRL_CLRINV_LSB = 11;
    localparam int CTRL_WIDTH = 13;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 13'h0000;
    // sizes
    localparam int IN_COUNT = 32;
    localparam int FB_COUNT = 9;
    localparam int LIT_COUNT = IN_COUNT + FB_COUNT;
    localparam int MC_COUNT = 16;
    localparam int TERM_COUNT = 2 * MC_COUNT;
    localparam int OUT_COUNT = 10;
    localparam int MEM_WORDS = 128;
    localparam int MEM_WIDTH = 16;
    localparam int ADDR_WIDTH = 11;
    localparam int ORG_DEEPEST = 4;
    // macrocell register types
    localparam logic [1:0] REG_D = 2'h0;
    localparam logic [1:0] REG_T = 2'h1;
    localparam logic [1:0] REG_JK = 2'h2;
    localparam logic [1:0] REG_SR = 2'h3;
    // clear selections
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_ZERO = 2'h1;
    localparam logic [1:0] CLR_ONE = 2'h2;
    // memory clocking arrangements
    localparam logic CLKMODE_RW = 1'b0;
    localparam logic CLKMODE_IO = 1'b1;
endpackage : embedded_block_pkg

// ---- src/mem_array.sv ----
`timescale 1ns/1ps
module mem_array
    import embedded_block_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [MEM_WIDTH-1:0] wmask,
    input wire logic [MEM_WIDTH-1:0] wdata,
    input wire logic [6:0] raddr,
    output logic [MEM_WIDTH-1:0] rdata
);
    typedef struct packed {
        logic [MEM_WORDS-1:0][MEM_WIDTH-1:0] mem;
        logic [MEM_WIDTH-1:0] rdata;
    } mem_state_t;

    mem_state_t st_r;
    mem_state_t st_nxt;

    // masked write keeps the other slices of the word; read always returns the old word
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rdata = st_r.mem[raddr];
        if (we)
        begin
            st_nxt.mem[waddr] = (st_r.mem[waddr] & ~wmask) | (wdata & wmask);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
endmodule : mem_array

// ---- src/embedded_block.sv ----
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Contract
// (R1) thirty-two local inputs are the only data path into the block
// (R2) nine macrocell outputs feed back as extra literals
// (R3) sixteen macrocells, two product terms and one register each
// (R4) each macrocell registered or combinational, bypassing its register
// (R5) each cell's terms go to its own OR/XOR or to the next cell
// (R6) second product term of each cell may be inverted
// (R7) register acts as D, T, JK or SR with selectable clock
// (R8) two block clocks, each with its paired enable
// (R9) rising and falling edges together need both block clocks
// (R10) two clears with optional inversion; each cell picks one or none
// (R11) an OR gathers up to 32 terms: own two plus 30 borrowed
// (R12) expanders chain in up to fifteen sets of two terms
// (R13) memory writes registered on clock; optional read-data output register
// (R14) read and write proceed together on different clocks
// (R15) block makes its own internal write strobe from the clock
// (R16) ten local outputs, nine distinct
// (R17) organisations 128x16, 256x8, 512x4, 1024x2, 2048x1
// (R18) page decoder enables shared-line driver only for own page
// (R19) four blocks share eleven address bits, two bits pick page
// (R20) shared line never driven by two blocks, never left floating
// (R21) read/write clock mode and input/output clock mode
// (R22) true dual port needs two blocks working together
// (R23) read/write mode: clock 0 write side, clock 1 read side
// (R24) input/output mode: clock 0 all inputs, clock 1 output register
// (R25) output register adds one clock; otherwise data follows address
module embedded_block
    import embedded_block_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [IN_COUNT-1:0] local_in,
    input wire logic [1:0] blk_clk,
    input wire logic [1:0] blk_clk_en,
    input wire logic [1:0] clr_src,
    input wire logic [ADDR_WIDTH-1:0] wr_addr,
    input wire logic write_enable,
    input wire logic [ADDR_WIDTH-1:0] rd_addr,
    input wire logic read_strobe,
    input wire logic [1:0] page_addr,
    output logic [OUT_COUNT-1:0] local_out,
    output logic [MC_COUNT-1:0] mc_out,
    output logic [MEM_WIDTH-1:0] mem_dout,
    output logic [MEM_WIDTH-1:0] shared_out,
    output logic shared_oe
);
    typedef struct packed {
        logic [CTRL_WIDTH-1:0] ctrl;
        logic [2*MC_COUNT-1:0] mc_type;
        logic [MC_COUNT-1:0] mc_reg;
        logic [MC_COUNT-1:0] mc_inv;
        logic [MC_COUNT-1:0] mc_export;
        logic [MC_COUNT-1:0] mc_xor;
        logic [MC_COUNT-1:0] mc_clk;
        logic [2*MC_COUNT-1:0] mc_clr;
        logic [TERM_COUNT-1:0][LIT_COUNT-1:0] pt_true;
        logic [TERM_COUNT-1:0][LIT_COUNT-1:0] pt_comp;
        logic [1:0][2:0] clk_sync;
        logic [1:0] clk_level;
        logic [MC_COUNT-1:0] mc_q;
        logic [MC_COUNT-1:0] mc_out;
        logic [ADDR_WIDTH-1:0] wr_addr;
        logic [MEM_WIDTH-1:0] wr_data;
        logic wr_strobe;
        logic [ADDR_WIDTH-1:0] rd_addr;
        logic [1:0] rd_page;
        logic [ADDR_WIDTH-1:0] rd_addr_d;
        logic [MEM_WIDTH-1:0] out_q;
    } blk_state_t;

    blk_state_t st_r;
    blk_state_t st_nxt;
    logic [LIT_COUNT-1:0] lit;
    logic [TERM_COUNT-1:0] term;
    logic [MC_COUNT:0] exp_chain;
    logic [MC_COUNT-1:0] mc_sum;
    logic [MC_COUNT-1:0] mc_t1;
    logic [1:0] clk_event;
    logic [1:0] clr_act;
    logic [2:0] org;
    logic mem_mode;
    logic [MEM_WIDTH-1:0] mem_rword;
    logic [MEM_WIDTH-1:0] rd_slice;
    logic [MEM_WIDTH-1:0] wmask;
    logic [MEM_WIDTH-1:0] wdata_rep;
    logic apb_wr;
    logic term_hit;
    logic [4:0] term_idx;

    // mask of the active data width for an organisation
    function automatic logic [MEM_WIDTH-1:0] width_mask(input logic [2:0] m);
        logic [MEM_WIDTH-1:0] r;
        r = 16'hffff;
        case (m)
            3'h1: r = 16'h00ff;
            3'h2: r = 16'h000f;
            3'h3: r = 16'h0003;
            3'h4: r = 16'h0001;
            default: r = 16'hffff;
        endcase
        return r;
    endfunction : width_mask

    // bit offset of the addressed slice inside a 16-bit word
    function automatic logic [3:0] slice_shift(input logic [2:0] m, input logic [ADDR_WIDTH-1:0] a);
        logic [3:0] r;
        r = 4'h0;
        case (m)
            3'h1: r = {a[0], 3'h0};
            3'h2: r = {a[1:0], 2'h0};
            3'h3: r = {a[2:0], 1'b0};
            3'h4: r = a[3:0];
            default: r = 4'h0;
        endcase
        return r;
    endfunction : slice_shift

    // word index: the low bits beyond the slice pick the word
    function automatic logic [6:0] word_idx(input logic [2:0] m, input logic [ADDR_WIDTH-1:0] a);
        logic [ADDR_WIDTH-1:0] s;
        s = a >> m;
        return s[6:0];
    endfunction : word_idx

    assign mem_mode = st_r.ctrl[CTRL_MODE_BIT];
    // organisations above the deepest read as the deepest, so the capacity never changes
    assign org = (st_r.ctrl[CTRL_ORG_LSB +: 3] > 3'(ORG_DEEPEST)) ? 3'(ORG_DEEPEST) : st_r.ctrl[CTRL_ORG_LSB +: 3]; // [R17]

    // literals are the local inputs plus the registered feedback outputs
    assign lit = {st_r.mc_out[FB_COUNT-1:0], local_in}; // [R1] [R2]

    // block clock edges: a change counts once the second and third stages agree
    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            // each block clock carries one edge, so mixed edges use both clocks [R9]
            clk_event[k] = blk_clk_en[k] & ((st_r.clk_sync[k][1] == st_r.clk_sync[k][2]) &
                (st_r.clk_sync[k][1] != st_r.clk_level[k]) &
                (st_r.clk_sync[k][1] ^ st_r.ctrl[CTRL_EDGE_LSB + k])); // [R8]
            clr_act[k] = clr_src[k] ^ st_r.ctrl[CTRL_CLRINV_LSB + k]; // [R10]
        end
    end

    // product terms, term inversion and the expander chain, one slice per macrocell
    assign exp_chain[0] = 1'b0;
    genvar gi;
    generate
        for (gi = 0; gi < MC_COUNT; gi++)
        begin : g_cell
            assign term[2*gi] = &(~st_r.pt_true[2*gi] | lit) & &(~st_r.pt_comp[2*gi] | ~lit); // [R3]
            assign term[2*gi+1] = &(~st_r.pt_true[2*gi+1] | lit) & &(~st_r.pt_comp[2*gi+1] | ~lit);
            assign mc_t1[gi] = term[2*gi+1] ^ st_r.mc_inv[gi]; // [R6]
            // exported terms leave this OR and join the next cell's; one set of two per link
            assign exp_chain[gi+1] = st_r.mc_export[gi] & (term[2*gi] | mc_t1[gi] | exp_chain[gi]); // [R5] [R12]
            assign mc_sum[gi] = (((~st_r.mc_export[gi]) & (term[2*gi] | mc_t1[gi])) | exp_chain[gi])
                ^ st_r.mc_xor[gi]; // [R11]
        end
    endgenerate

    // memory write data replicated across slices and masked to the addressed one
    assign wmask = width_mask(org) << slice_shift(org, st_r.wr_addr);
    always_comb
    begin
        wdata_rep = st_r.wr_data;
        case (org)
            3'h1: wdata_rep = {2{st_r.wr_data[7:0]}};
            3'h2: wdata_rep = {4{st_r.wr_data[3:0]}};
            3'h3: wdata_rep = {8{st_r.wr_data[1:0]}};
            3'h4: wdata_rep = {16{st_r.wr_data[0]}};
            default: wdata_rep = st_r.wr_data;
        endcase
    end

    mem_array u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(st_r.wr_strobe & mem_mode), // [R15]
        .waddr(word_idx(org, st_r.wr_addr)),
        .wmask(wmask),
        .wdata(wdata_rep),
        .raddr(word_idx(org, st_r.rd_addr)),
        .rdata(mem_rword)
    );

    // read slice uses the address that produced the word one cycle ago
    assign rd_slice = (mem_rword >> slice_shift(org, st_r.rd_addr_d)) & width_mask(org);

    // apb decode; the slave never stalls
    assign apb_wr = psel & penable & pwrite;
    assign term_hit = (paddr >= TERM_BASE_ADDR) && (paddr <= TERM_END_ADDR);
    assign term_idx = 5'((paddr - TERM_BASE_ADDR) >> 4);

    // next state of the whole block
    always_comb
    begin
        st_nxt = st_r;
        for (int k = 0; k < 2; k++)
        begin
            st_nxt.clk_sync[k] = {st_r.clk_sync[k][1:0], blk_clk[k]};
            if (st_r.clk_sync[k][1] == st_r.clk_sync[k][2])
            begin
                st_nxt.clk_level[k] = st_r.clk_sync[k][1];
            end
        end
        // macrocell registers; clear overrides any clock event
        for (int i = 0; i < MC_COUNT; i++)
        begin
            if (clk_event[st_r.mc_clk[i]]) // [R8]
            begin
                unique case (st_r.mc_type[2*i +: 2]) // [R7]
                    REG_D: st_nxt.mc_q[i] = mc_sum[i];
                    REG_T: st_nxt.mc_q[i] = st_r.mc_q[i] ^ mc_sum[i];
                    REG_JK: st_nxt.mc_q[i] = (term[2*i] & ~st_r.mc_q[i]) | (~mc_t1[i] & st_r.mc_q[i]);
                    REG_SR: st_nxt.mc_q[i] = term[2*i] | (~mc_t1[i] & st_r.mc_q[i]);
                endcase
            end
            if (((st_r.mc_clr[2*i +: 2] == CLR_ZERO) && clr_act[0]) ||
                ((st_r.mc_clr[2*i +: 2] == CLR_ONE) && clr_act[1])) // [R10]
            begin
                st_nxt.mc_q[i] = 1'b0;
            end
            // bypass the register for combinational cells
            st_nxt.mc_out[i] = mem_mode ? 1'b0 : (st_r.mc_reg[i] ? st_r.mc_q[i] : mc_sum[i]); // [R4]
        end
        // write side always sits on clock 0 [R23] [R24]
        st_nxt.wr_strobe = 1'b0;
        if (clk_event[0])
        begin
            st_nxt.wr_addr = wr_addr;
            st_nxt.wr_data = local_in[MEM_WIDTH-1:0];
            st_nxt.wr_strobe = write_enable; // [R13] [R15]
        end
        // read address on clock 1 in read/write mode, clock 0 in input/output mode
        if (read_strobe && clk_event[(st_r.ctrl[CTRL_CLKMODE_BIT] == CLKMODE_IO) ? 0 : 1]) // [R14] [R21]
        begin
            st_nxt.rd_addr = rd_addr;
            st_nxt.rd_page = page_addr; // [R19]
        end
        st_nxt.rd_addr_d = st_r.rd_addr;
        // output register always on clock 1
        if (clk_event[1])
        begin
            st_nxt.out_q = rd_slice; // [R25]
        end
        if (apb_wr)
        begin
            if (paddr == CTRL_ADDR)
            begin
                st_nxt.ctrl = pwdata[CTRL_WIDTH-1:0];
            end
            if (paddr == MC_TYPE_ADDR)
            begin
                st_nxt.mc_type = pwdata;
            end
            if (paddr == MC_CFG_ADDR)
            begin
                st_nxt.mc_reg = pwdata[15:0];
                st_nxt.mc_inv = pwdata[31:16];
            end
            if (paddr == MC_EXP_ADDR)
            begin
                // the last cell has no neighbour to feed
                st_nxt.mc_export = {1'b0, pwdata[14:0]};
                st_nxt.mc_xor = pwdata[31:16];
            end
            if (paddr == MC_CLK_ADDR)
            begin
                st_nxt.mc_clk = pwdata[15:0];
            end
            if (paddr == MC_CLR_ADDR)
            begin
                st_nxt.mc_clr = pwdata;
            end
            if (term_hit)
            begin
                unique case (paddr[3:2])
                    2'h0: st_nxt.pt_true[term_idx][31:0] = pwdata;
                    2'h1: st_nxt.pt_true[term_idx][LIT_COUNT-1:32] = pwdata[FB_COUNT-1:0];
                    2'h2: st_nxt.pt_comp[term_idx][31:0] = pwdata;
                    2'h3: st_nxt.pt_comp[term_idx][LIT_COUNT-1:32] = pwdata[FB_COUNT-1:0];
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.ctrl <= CTRL_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // read mux; unmapped addresses answer zero with an error
    always_comb
    begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == CTRL_ADDR)
            prdata = {19'h0, st_r.ctrl};
        else if (paddr == MC_TYPE_ADDR)
            prdata = st_r.mc_type;
        else if (paddr == MC_CFG_ADDR)
            prdata = {st_r.mc_inv, st_r.mc_reg};
        else if (paddr == MC_EXP_ADDR)
            prdata = {st_r.mc_xor, st_r.mc_export};
        else if (paddr == MC_CLK_ADDR)
            prdata = {16'h0, st_r.mc_clk};
        else if (paddr == MC_CLR_ADDR)
            prdata = st_r.mc_clr;
        else if (paddr == STATUS_ADDR)
            prdata = {mem_dout, st_r.mc_q};
        else if (term_hit)
        begin
            unique case (paddr[3:2])
                2'h0: prdata = st_r.pt_true[term_idx][31:0];
                2'h1: prdata = {23'h0, st_r.pt_true[term_idx][LIT_COUNT-1:32]};
                2'h2: prdata = st_r.pt_comp[term_idx][31:0];
                2'h3: prdata = {23'h0, st_r.pt_comp[term_idx][LIT_COUNT-1:32]};
            endcase
        end
        else
            pslverr = psel & penable;
    end
    assign pready = 1'b1;

    // outputs; a second block joins the shared line for a true dual port [R22]
    assign mc_out = st_r.mc_out;
    assign mem_dout = mem_mode ? (st_r.ctrl[CTRL_OUTREG_BIT] ? st_r.out_q : rd_slice) : 16'h0000; // [R13] [R25]
    assign local_out[FB_COUNT-1:0] = mem_mode ? mem_dout[FB_COUNT-1:0] : st_r.mc_out[FB_COUNT-1:0];
    assign local_out[OUT_COUNT-1] = local_out[FB_COUNT-1]; // [R16]
    // only the addressed page drives, so at most one of four blocks is ever on [R20]
    assign shared_oe = mem_mode & st_r.ctrl[CTRL_PAGEEN_BIT] & (st_r.rd_page == st_r.ctrl[CTRL_PAGEID_LSB +: 2]); // [R18]
    assign shared_out = shared_oe ? mem_dout : 16'h0000;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_read_load;
        read_strobe && clk_event[1] && (st_r.ctrl[CTRL_CLKMODE_BIT] == CLKMODE_RW);
    endsequence

    property p_feedback;
        lit[LIT_COUNT-1:IN_COUNT] == mc_out[FB_COUNT-1:0] && lit[IN_COUNT-1:0] == local_in;
    endproperty
    a_feedback: assert property (p_feedback) else $error("feedback literals wrong"); // [R2]

    property p_bypass;
        (!mem_mode && !st_r.mc_reg[0]) ##1 !$past(mem_mode) |-> mc_out[0] == $past(mc_sum[0]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("combinational cell not bypassed"); // [R4]

    property p_dff;
        (!mem_mode && clk_event[st_r.mc_clk[0]] && st_r.mc_type[1:0] == REG_D && !clr_act[0] && !clr_act[1])
            |=> st_r.mc_q[0] == $past(mc_sum[0]);
    endproperty
    a_dff: assert property (p_dff) else $error("d register did not load"); // [R7]

    property p_hold;
        (!clk_event[st_r.mc_clk[0]] && !clr_act[0] && !clr_act[1]) |=> $stable(st_r.mc_q[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without its clock"); // [R8]

    property p_clear;
        ((st_r.mc_clr[1:0] == CLR_ZERO && clr_act[0]) || (st_r.mc_clr[1:0] == CLR_ONE && clr_act[1]))
            |=> !st_r.mc_q[0];
    endproperty
    a_clear: assert property (p_clear) else $error("selected clear did not clear"); // [R10]

    property p_dup;
        local_out[OUT_COUNT-1] == local_out[FB_COUNT-1];
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate local output differs"); // [R16]

    property p_page;
        shared_oe |-> mem_mode && st_r.rd_page == st_r.ctrl[CTRL_PAGEID_LSB +: 2];
    endproperty
    a_page: assert property (p_page) else $error("driver on for a foreign page"); // [R18]

    property p_rw_read;
        s_read_load |=> st_r.rd_addr == $past(rd_addr) ##1 st_r.rd_addr_d == $past(rd_addr, 2);
    endproperty
    a_rw_read: assert property (p_rw_read) else $error("read side not on clock 1"); // [R23]

    property p_io_hold;
        (st_r.ctrl[CTRL_CLKMODE_BIT] == CLKMODE_IO && !clk_event[0]) |=> $stable(st_r.rd_addr);
    endproperty
    a_io_hold: assert property (p_io_hold) else $error("read address moved off clock 0"); // [R24]

    property p_strobe;
        st_r.wr_strobe |=> !st_r.wr_strobe || $past(clk_event[0]);
    endproperty
    a_strobe: assert property (p_strobe) else $error("write strobe longer than one cycle"); // [R15]

    property p_outreg;
        (mem_mode && st_r.ctrl[CTRL_OUTREG_BIT] && !clk_event[1]) ##1 $stable(st_r.ctrl) |-> $stable(mem_dout);
    endproperty
    a_outreg: assert property (p_outreg) else $error("registered read data moved without clock 1"); // [R25]
endmodule : embedded_block

// ---- test/fabric_model.sv ----
`timescale 1ns/1ps
// neighbouring fabric logic: drives the two block-wide clock pins
module fabric_model
(
    input wire logic pclk,
    output logic [1:0] blk_clk
);
    initial blk_clk = 2'h0;
    // one pin pulse, each level held four pclk since the synchroniser needs three
    task automatic pulse(input int c);
        blk_clk[c] <= 1'b1;
        repeat (4) @(posedge pclk);
        blk_clk[c] <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : pulse
endmodule : fabric_model

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
    import embedded_block_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, shared_oe;
    logic write_enable = 0, read_strobe = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, local_in = 32'h0;
    logic [1:0] blk_clk, blk_clk_en = 2'h3, clr_src = 2'h0, page_addr = 2'h0;
    logic [10:0] wr_addr = 11'h000, rd_addr = 11'h000;
    logic [9:0] local_out;
    logic [15:0] mc_out, mem_dout, shared_out, d, q;
    logic e;
    int seed = 67, fail_count = 0, compares = 0, a, o, k;
    // 125 MHz
    always #4 pclk = ~pclk;
    fabric_model i_fab (.pclk(pclk), .blk_clk(blk_clk));
    embedded_block i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .local_in(local_in), .blk_clk(blk_clk), .blk_clk_en(blk_clk_en), .clr_src(clr_src),
        .wr_addr(wr_addr), .write_enable(write_enable), .rd_addr(rd_addr), .read_strobe(read_strobe),
        .page_addr(page_addr), .local_out(local_out), .mc_out(mc_out), .mem_dout(mem_dout),
        .shared_out(shared_out), .shared_oe(shared_oe));
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // one apb transfer; waits for pready, then an idle edge so psel never toggles twice in a step
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= ad;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic mem_wr(input int ad, input logic [15:0] wd);
        wr_addr <= ad[10:0];
        local_in <= {16'h0000, wd};
        write_enable <= 1'b1;
        i_fab.pulse(0);
        write_enable <= 1'b0;
    endtask : mem_wr
    task automatic mem_rd(input int ad, input logic [1:0] pg, input int c);
        rd_addr <= ad[10:0];
        page_addr <= pg;
        read_strobe <= 1'b1;
        i_fab.pulse(c);
        read_strobe <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : mem_rd
    // only page 2 may drive the shared line
    function automatic logic [15:0] exp_shared(input logic [1:0] pg, input logic [15:0] wd);
        return (pg == 2'h2) ? wd : 16'h0000;
    endfunction : exp_shared
    // a full run costs far less than this many cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, CTRL_ADDR, 0);
        chk("ctrl reset", 0, r);
        chk("mapped err", 0, e);
        apb(0, 12'h020, 0);
        chk("unmapped data", 0, r);
        chk("unmapped err", 1, e);
        apb(0, STATUS_ADDR, 0);
        chk("status reset", 0, r);
        apb(1, STATUS_ADDR, 32'hffffffff);
        apb(0, STATUS_ADDR, 0);
        chk("status ro", 0, r);
        $display("test registers done");
        // cell 0: term0 = lit0, term1 = lit0 & ~lit0, combinational
        apb(1, 12'h100, 1);
        apb(1, 12'h110, 1);
        apb(1, 12'h118, 1);
        apb(0, 12'h118, 0);
        chk("term mask", 1, r);
        for (k = 0; k < 8; k++)
        begin
            local_in <= $random(seed);
            repeat (3) @(posedge pclk);
            chk("comb cell", local_in[0], mc_out[0]);
            chk("local out", local_in[0], local_out[0]);
            chk("local dup", 1, local_out[9]);
        end
        apb(1, MC_CFG_ADDR, 32'h00010000);
        local_in <= 32'h0;
        repeat (3) @(posedge pclk);
        chk("invert term", 1, mc_out[0]);
        // cell 1 gets false terms of its own and borrows both terms of cell 0
        for (k = 0; k < 4; k++)
            apb(1, 12'h120 + 12'(k * 8), 2);
        apb(1, MC_CFG_ADDR, 0);
        apb(1, MC_EXP_ADDR, 1);
        for (k = 0; k < 4; k++)
        begin
            local_in <= $random(seed);
            repeat (3) @(posedge pclk);
            chk("expander", local_in[0], mc_out[1]);
            chk("lender off", 0, mc_out[0]);
        end
        apb(1, MC_EXP_ADDR, 0);
        // registered D then T on clock 0
        apb(1, MC_CFG_ADDR, 1);
        apb(1, MC_CLK_ADDR, 0);
        apb(1, MC_TYPE_ADDR, {30'h0, REG_D});
        local_in <= 32'h1;
        blk_clk_en <= 2'h1;
        i_fab.pulse(0);
        chk("d load", 1, mc_out[0]);
        local_in <= 32'h0;
        blk_clk_en <= 2'h0;
        i_fab.pulse(0);
        chk("enable off", 1, mc_out[0]);
        apb(1, MC_TYPE_ADDR, {30'h0, REG_T});
        local_in <= 32'h1;
        blk_clk_en <= 2'h1;
        q = 16'h1;
        for (k = 0; k < 2; k++)
        begin
            i_fab.pulse(0);
            q = ~q;
            chk("t toggle", q[0], mc_out[0]);
        end
        apb(1, MC_CLR_ADDR, {30'h0, CLR_ZERO});
        clr_src <= 2'h1;
        repeat (3) @(posedge pclk);
        chk("clear", 0, mc_out[0]);
        clr_src <= 2'h0;
        blk_clk_en <= 2'h3;
        $display("test product terms done");
        // every organisation, page id 2, read/write clocks
        for (o = 0; o < 5; o++)
        begin
            apb(1, CTRL_ADDR, 32'h141 | (o << 1));
            for (k = 0; k < 3; k++)
            begin
                a = $random(seed) & ((128 << o) - 1);
                d = $random(seed) & ((1 << (16 >> o)) - 1);
                mem_wr(a, d);
                mem_rd(a, k[1:0] + 2'h1, 1);
                chk("mem read", d, mem_dout);
                chk("mc off", 0, mc_out);
                chk("shared oe", (k == 1), shared_oe);
                chk("shared out", exp_shared(k[1:0] + 2'h1, d), shared_out);
            end
        end
        // input/output clock mode: clock 0 captures the read address too
        apb(1, CTRL_ADDR, 32'h21);
        a = $random(seed) & 127;
        d = $random(seed);
        mem_wr(a, d);
        mem_rd(a, 2'h0, 0);
        chk("io mode read", d, mem_dout);
        // output register on: data only moves on a clock 1 event
        apb(1, CTRL_ADDR, 32'h31);
        i_fab.pulse(1);
        chk("out reg read", d, mem_dout);
        $display("test memory done");
        report_and_stop();
    end
endmodule : tb
